// [hw/cmp_channel.sv]
// one comparator channel: result, change flag and settling timer
// assumes a level already synchronised to clk_sys
`include "cmp_defs.svh"

module cmp_channel
    import cmp_pkg::*;
#(
    parameter int SETTLE_CYCLES = `CMP_SETTLE_CYC
)
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // control
    input  wire logic level,
    input  wire logic active,
    input  wire logic flag_clr,
    // state
    output logic      result,
    output logic      flag,
    output logic      settled
);

    generate
        if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << `CMP_CNT_W)) begin : g_bad
            $error("SETTLE_CYCLES out of range");
        end
    endgenerate

    localparam logic [`CMP_CNT_W-1:0] SETTLE_LAST = `CMP_CNT_W'(SETTLE_CYCLES);

    chan_state_type st_reg;
    chan_state_type st_next;
    logic           res_new;

    always_comb begin
        st_next = st_reg;
        // disabled channel forces its result high
        res_new = active ? level : 1'b1;
        st_next.result = res_new;
        // any change, forced ones included, sets the flag; set beats clear
        st_next.flag = (st_reg.flag & ~flag_clr) | (res_new != st_reg.result);
        if (!active) begin
            st_next.cnt     = '0;
            st_next.settled = 1'b0;
        end else if (st_reg.cnt != SETTLE_LAST) begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end else begin
            st_next.settled = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_reg        <= '0;
            st_reg.result <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign result  = st_reg.result;
    assign flag    = st_reg.flag;
    assign settled = st_reg.settled;

endmodule

// [hw/cmp_defs.svh]
// register map, field positions, reset values and timing counts of the comparator control block
// assumes an 8-bit register port and a 250 MHz system clock
`ifndef CMP_DEFS_SVH
`define CMP_DEFS_SVH

`define CMP_ADDR_W       4
`define CMP_DATA_W       8
`define CMP_CHANNELS     2

`define CMP_OFS_CFG0     4'h0
`define CMP_OFS_CFG1     4'h1
`define CMP_OFS_FLAGS    4'h2
`define CMP_OFS_MASK     4'h3
`define CMP_OFS_PWR      4'h4

`define CMP_CFG_EN       0
`define CMP_CFG_PIN      1
`define CMP_CFG_POS      2
`define CMP_CFG_NEGREF   3
`define CMP_CFG_RESULT   4
`define CMP_CFG_IE       5
`define CMP_CFG_FLAG     6
`define CMP_CFG_SETTLED  7

`define CMP_PWR_OFF      5

`define CMP_CFG_RESET    5'h00
`define CMP_RDATA_RESET  8'h00

`define CMP_CLK_NS       4
`define CMP_SETTLE_NS    10000
`define CMP_SETTLE_CYC   ((`CMP_SETTLE_NS + `CMP_CLK_NS - 1) / `CMP_CLK_NS)
`define CMP_CNT_W        12

`endif

// [hw/cmp_pkg.sv]
// types shared by the comparator control block
// assumes cmp_defs.svh is on the include path
`include "cmp_defs.svh"

package cmp_pkg;

    typedef struct packed {
        logic ie;
        logic neg_ref;
        logic pos_sel;
        logic pin_out;
        logic en;
    } ch_cfg_type;

    typedef struct packed {
        logic [`CMP_CHANNELS-1:0] s1;
        logic [`CMP_CHANNELS-1:0] s2;
        logic [`CMP_CHANNELS-1:0] s3;
        logic [`CMP_CHANNELS-1:0] level;
    } sync_state_type;

    typedef struct packed {
        logic                 result;
        logic                 flag;
        logic                 settled;
        logic [`CMP_CNT_W-1:0] cnt;
    } chan_state_type;

    typedef struct packed {
        ch_cfg_type [`CMP_CHANNELS-1:0] cfg;
        logic                           pwr_off;
        logic [`CMP_DATA_W-1:0]         rdata;
        logic                           irq;
        logic                           wake;
        logic [`CMP_CHANNELS-1:0]       cmp_enable;
        logic [`CMP_CHANNELS-1:0]       pos_sel;
        logic [`CMP_CHANNELS-1:0]       neg_ref;
        logic                           ref_enable;
        logic [`CMP_CHANNELS-1:0]       pin_out;
        logic [`CMP_CHANNELS-1:0]       pin_oe;
    } top_state_type;

endpackage

// [hw/cmp_sync.sv]
// three-stage synchroniser for the raw comparator outputs
// assumes inputs come from asynchronous analog cores
`include "cmp_defs.svh"

module cmp_sync
    import cmp_pkg::*;
(
    // clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     reset,
    // asynchronous levels in, clean levels out
    input  wire logic [`CMP_CHANNELS-1:0] raw,
    output logic      [`CMP_CHANNELS-1:0] level
);

    sync_state_type st_reg;
    sync_state_type st_next;

    // a new level counts only once the second and third stages agree
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = raw;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < `CMP_CHANNELS; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.level[i] = st_reg.s3[i];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level = st_reg.level;

endmodule

// [hw/dual_comparator_control.sv]
// control, change detection and interrupt logic around two analog comparators
// assumes analog cores outside, a synchronous register port and mode levels from clk_sys logic
//
// Operation
// - two channels, each configured on its own
// - result is one when positive exceeds negative
// - two positive sources, negative pin or reference
// - any result change sets the channel flag
// - enabled flags share one interrupt line
// - disabled channel result forced high
// - forced low-to-high change sets flag too
// - total power-down disables both channels
// - enabled change wakes processor from idle or power-down, not from total power-down
// - power control bit five switches comparators off
// - internal reference usable as negative input
//
// The placing of the registers and the strobed register port were left to the implementer.
`include "cmp_defs.svh"

module dual_comparator_control
    import cmp_pkg::*;
#(
    parameter int SETTLE_CYCLES = `CMP_SETTLE_CYC
)
(
    // clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     reset,
    // register port
    input  wire logic [`CMP_ADDR_W-1:0]   addr,
    input  wire logic [`CMP_DATA_W-1:0]   wdata,
    input  wire logic                     wr,
    input  wire logic                     rd,
    output logic      [`CMP_DATA_W-1:0]   rdata,
    // analog comparator cores
    input  wire logic [`CMP_CHANNELS-1:0] cmp_raw,
    output logic      [`CMP_CHANNELS-1:0] cmp_enable,
    output logic      [`CMP_CHANNELS-1:0] pos_sel,
    output logic      [`CMP_CHANNELS-1:0] neg_ref,
    output logic                          ref_enable,
    // result pins
    output logic      [`CMP_CHANNELS-1:0] cmp_pin_out,
    output logic      [`CMP_CHANNELS-1:0] cmp_pin_oe,
    // power modes
    input  wire logic                     idle_mode,
    input  wire logic                     power_down_mode,
    input  wire logic                     total_power_down,
    // interrupt and wake
    output logic                          irq,
    output logic                          wake_req
);

    top_state_type            st_reg;
    top_state_type            st_next;
    logic [`CMP_CHANNELS-1:0] level;
    logic [`CMP_CHANNELS-1:0] act;
    logic [`CMP_CHANNELS-1:0] clr;
    logic [`CMP_CHANNELS-1:0] res;
    logic [`CMP_CHANNELS-1:0] flag;
    logic [`CMP_CHANNELS-1:0] settled;
    logic [`CMP_CHANNELS-1:0] ie;
    logic                     pending;

    generate
        if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << `CMP_CNT_W)) begin : g_bad_settle
            $error("SETTLE_CYCLES out of range");
        end
    endgenerate

    // configuration byte as software sees it
    function automatic logic [`CMP_DATA_W-1:0] cfg_byte(
        input ch_cfg_type c,
        input logic       r,
        input logic       f,
        input logic       s
    );
        logic [`CMP_DATA_W-1:0] b;
        b                   = '0;
        b[`CMP_CFG_EN]      = c.en;
        b[`CMP_CFG_PIN]     = c.pin_out;
        b[`CMP_CFG_POS]     = c.pos_sel;
        b[`CMP_CFG_NEGREF]  = c.neg_ref;
        b[`CMP_CFG_RESULT]  = r;
        b[`CMP_CFG_IE]      = c.ie;
        b[`CMP_CFG_FLAG]    = f;
        b[`CMP_CFG_SETTLED] = s;
        return b;
    endfunction

    // configuration fields taken from a write
    function automatic ch_cfg_type cfg_from(input logic [`CMP_DATA_W-1:0] d);
        ch_cfg_type c;
        c.en      = d[`CMP_CFG_EN];
        c.pin_out = d[`CMP_CFG_PIN];
        c.pos_sel = d[`CMP_CFG_POS];
        c.neg_ref = d[`CMP_CFG_NEGREF];
        c.ie      = d[`CMP_CFG_IE];
        return c;
    endfunction

    cmp_sync u_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .raw     (cmp_raw),
        .level   (level)
    );

    generate
        for (genvar g = 0; g < `CMP_CHANNELS; g++) begin : g_ch
            cmp_channel #(
                .SETTLE_CYCLES (SETTLE_CYCLES)
            ) u_ch (
                .clk_sys  (clk_sys),
                .reset    (reset),
                .level    (level[g]),
                .active   (act[g]),
                .flag_clr (clr[g]),
                .result   (res[g]),
                .flag     (flag[g]),
                .settled  (settled[g])
            );
        end
    endgenerate

    always_comb begin
        st_next = st_reg;
        pending = 1'b0;
        for (int i = 0; i < `CMP_CHANNELS; i++) begin
            ie[i]  = st_reg.cfg[i].ie;
            // gated off by its own enable, the power control bit or total power-down
            act[i] = st_reg.cfg[i].en & ~st_reg.pwr_off & ~total_power_down;
            clr[i] = 1'b0;
            if (wr && addr == (`CMP_OFS_CFG0 + `CMP_ADDR_W'(i)) && !wdata[`CMP_CFG_FLAG]) begin
                clr[i] = 1'b1;
            end
            if (wr && addr == `CMP_OFS_FLAGS && wdata[i]) begin
                clr[i] = 1'b1;
            end
            pending = pending | (flag[i] & ie[i]);
        end

        // register writes
        if (wr) begin
            case (addr)
                `CMP_OFS_CFG0: begin
                    st_next.cfg[0] = cfg_from(wdata);
                end
                `CMP_OFS_CFG1: begin
                    st_next.cfg[1] = cfg_from(wdata);
                end
                `CMP_OFS_MASK: begin
                    for (int i = 0; i < `CMP_CHANNELS; i++) begin
                        st_next.cfg[i].ie = wdata[i];
                    end
                end
                `CMP_OFS_PWR: begin
                    st_next.pwr_off = wdata[`CMP_PWR_OFF];
                end
                default: begin
                end
            endcase
        end

        // register reads, answered in the next cycle; unmapped reads give zero
        st_next.rdata = `CMP_RDATA_RESET;
        if (rd) begin
            case (addr)
                `CMP_OFS_CFG0: begin
                    st_next.rdata = cfg_byte(st_reg.cfg[0], res[0], flag[0], settled[0]);
                end
                `CMP_OFS_CFG1: begin
                    st_next.rdata = cfg_byte(st_reg.cfg[1], res[1], flag[1], settled[1]);
                end
                `CMP_OFS_FLAGS: begin
                    st_next.rdata[`CMP_CHANNELS-1:0] = flag;
                end
                `CMP_OFS_MASK: begin
                    st_next.rdata[`CMP_CHANNELS-1:0] = ie;
                end
                `CMP_OFS_PWR: begin
                    st_next.rdata[`CMP_PWR_OFF] = st_reg.pwr_off;
                end
                default: begin
                end
            endcase
        end

        // analog controls and pins
        for (int i = 0; i < `CMP_CHANNELS; i++) begin
            st_next.cmp_enable[i] = act[i];
            st_next.pos_sel[i]    = st_reg.cfg[i].pos_sel;
            st_next.neg_ref[i]    = st_reg.cfg[i].neg_ref;
            st_next.pin_out[i]    = res[i];
            st_next.pin_oe[i]     = st_reg.cfg[i].pin_out;
        end
        st_next.ref_enable = |(act & {st_reg.cfg[1].neg_ref, st_reg.cfg[0].neg_ref});

        st_next.irq  = pending;
        st_next.wake = pending & (idle_mode | power_down_mode) & ~total_power_down;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata       = st_reg.rdata;
    assign cmp_enable  = st_reg.cmp_enable;
    assign pos_sel     = st_reg.pos_sel;
    assign neg_ref     = st_reg.neg_ref;
    assign ref_enable  = st_reg.ref_enable;
    assign cmp_pin_out = st_reg.pin_out;
    assign cmp_pin_oe  = st_reg.pin_oe;
    assign irq         = st_reg.irq;
    assign wake_req    = st_reg.wake;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    // writing channel 1 leaves channel 0 alone
    property p_indep;
        wr && addr == `CMP_OFS_CFG1 |=> $stable(st_reg.cfg[0]);
    endproperty
    a_indep: assert property (p_indep) else $error("cfg1 write disturbed channel 0");

    property p_read_result;
        rd && addr == `CMP_OFS_CFG0 |=> rdata[`CMP_CFG_RESULT] == $past(res[0]);
    endproperty
    a_read_result: assert property (p_read_result) else $error("read result mismatch");

    property p_pos_sel;
        wr && addr == `CMP_OFS_CFG1 |-> ##2 pos_sel[1] == $past(wdata[`CMP_CFG_POS], 2);
    endproperty
    a_pos_sel: assert property (p_pos_sel) else $error("positive input select not applied");

    property p_change_flag;
        res[0] != $past(res[0]) |-> flag[0];
    endproperty
    a_change_flag: assert property (p_change_flag) else $error("result change without flag");

    property p_irq;
        (|(flag & ie)) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("enabled flag did not raise irq");

    property p_no_irq;
        !(|(flag & ie)) |=> !irq;
    endproperty
    a_no_irq: assert property (p_no_irq) else $error("irq without enabled flag");

    property p_forced_high;
        !act[0] |=> res[0];
    endproperty
    a_forced_high: assert property (p_forced_high) else $error("disabled result not high");

    property p_disable_flag;
        $fell(act[1]) && !res[1] |=> res[1] && flag[1];
    endproperty
    a_disable_flag: assert property (p_disable_flag) else $error("disable edge did not set flag");

    property p_tpd;
        total_power_down |=> cmp_enable == '0;
    endproperty
    a_tpd: assert property (p_tpd) else $error("channel enabled in total power-down");

    property p_wake;
        (|(flag & ie)) && (idle_mode || power_down_mode) && !total_power_down |=> wake_req;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on enabled change");

    property p_pwr_off;
        wr && addr == `CMP_OFS_PWR && wdata[`CMP_PWR_OFF] |-> ##2 cmp_enable == '0;
    endproperty
    a_pwr_off: assert property (p_pwr_off) else $error("power control bit did not disable");

    property p_ref;
        act[0] && st_reg.cfg[0].neg_ref |=> ref_enable && neg_ref[0];
    endproperty
    a_ref: assert property (p_ref) else $error("reference not enabled");

    property p_clear;
        wr && addr == `CMP_OFS_CFG0 && !wdata[`CMP_CFG_FLAG] |=> !flag[0] || res[0] != $past(res[0]);
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared by zero write");

    property p_read_flag;
        rd && addr == `CMP_OFS_CFG1 |=> rdata[`CMP_CFG_FLAG] == $past(flag[1]);
    endproperty
    a_read_flag: assert property (p_read_flag) else $error("read flag mismatch");

    property p_flag_set1;
        res[1] != $past(res[1]) |-> flag[1];
    endproperty
    a_flag_set1: assert property (p_flag_set1) else $error("channel 1 change without flag");

    property p_flag_hold;
        flag[0] && !clr[0] |=> flag[0];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear");

    property p_flags_reg;
        rd && addr == `CMP_OFS_FLAGS |=> rdata[`CMP_CHANNELS-1:0] == $past(flag);
    endproperty
    a_flags_reg: assert property (p_flags_reg) else $error("flag register read mismatch");

    property p_forced_high1;
        !act[1] |=> res[1];
    endproperty
    a_forced_high1: assert property (p_forced_high1) else $error("disabled channel 1 result not high");

    property p_pin_follow;
        1'b1 |=> cmp_pin_out == $past(res);
    endproperty
    a_pin_follow: assert property (p_pin_follow) else $error("result pin does not follow result");

    property p_neg_sel;
        wr && addr == `CMP_OFS_CFG0 |-> ##2 neg_ref[0] == $past(wdata[`CMP_CFG_NEGREF], 2);
    endproperty
    a_neg_sel: assert property (p_neg_sel) else $error("negative input select not applied");

    property p_ref_off;
        act == '0 |=> !ref_enable;
    endproperty
    a_ref_off: assert property (p_ref_off) else $error("reference on with no active channel");

    property p_tpd_result;
        total_power_down |=> &res;
    endproperty
    a_tpd_result: assert property (p_tpd_result) else $error("result not forced high in total power-down");

    property p_no_wake_tpd;
        total_power_down |=> !wake_req;
    endproperty
    a_no_wake_tpd: assert property (p_no_wake_tpd) else $error("wake raised in total power-down");

    property p_wake_none;
        !(idle_mode || power_down_mode) |=> !wake_req;
    endproperty
    a_wake_none: assert property (p_wake_none) else $error("wake raised outside low power");

    property p_enable_follow;
        1'b1 |=> cmp_enable == $past(act);
    endproperty
    a_enable_follow: assert property (p_enable_follow) else $error("core enable does not follow channel");

endmodule

// [test/cmp_core_model.sv]
// behavioural model of the two analog comparator cores and their input muxes
// assumes input voltages in millivolts from the bench and the core controls of the block
module cmp_core_model #(
    parameter logic [11:0] REF_MV = 12'h4CE
)
(
    // clock for the idle pattern
    input  wire logic             clk_sys,
    // core controls
    input  wire logic [1:0]       cmp_enable,
    input  wire logic [1:0]       pos_sel,
    input  wire logic [1:0]       neg_ref,
    input  wire logic             ref_enable,
    // analog inputs
    input  wire logic [1:0][11:0] pos_a_mv,
    input  wire logic [1:0][11:0] pos_b_mv,
    input  wire logic [1:0][11:0] neg_mv,
    // raw outputs
    output logic      [1:0]       cmp_raw
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0]       idle_pat = 2'b01;
    logic [1:0][11:0] pos_v;
    logic [1:0][11:0] neg_v;
    // a powered-off core gives no valid level
    always @(posedge clk_sys) idle_pat <= ~idle_pat;
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pos_v[i] = pos_sel[i] ? pos_b_mv[i] : pos_a_mv[i];
            // reference reads zero while its generator is off
            neg_v[i] = neg_ref[i] ? (ref_enable ? REF_MV : 12'h000) : neg_mv[i];
            cmp_raw[i] = cmp_enable[i] ? (pos_v[i] > neg_v[i]) : idle_pat[i];
        end
    end
endmodule

// [test/test_dual_comparator_control.sv]
// self-checking bench of the comparator control block
// assumes the core model on the analog side and a shortened settling count
`include "cmp_defs.svh"
module test_dual_comparator_control;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [1:0] cmp_raw, cmp_enable, pos_sel, neg_ref, cmp_pin_out, cmp_pin_oe;
    logic ref_enable, irq, wake_req;
    logic idle_mode = 1'b0;
    logic power_down_mode = 1'b0;
    logic total_power_down = 1'b0;
    logic [1:0][11:0] pa_mv = '0;
    logic [1:0][11:0] pb_mv = '0;
    logic [1:0][11:0] n_mv = '0;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;
    logic [7:0] cfg [2];
    logic [1:0] prv, nxt, flg;

    always #2 clk_sys = ~clk_sys;

    dual_comparator_control #(.SETTLE_CYCLES(8)) i_dut (.clk_sys(clk_sys), .reset(reset), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cmp_raw(cmp_raw), .cmp_enable(cmp_enable),
        .pos_sel(pos_sel), .neg_ref(neg_ref), .ref_enable(ref_enable), .cmp_pin_out(cmp_pin_out),
        .cmp_pin_oe(cmp_pin_oe), .idle_mode(idle_mode), .power_down_mode(power_down_mode),
        .total_power_down(total_power_down), .irq(irq), .wake_req(wake_req));

    cmp_core_model i_cores (.clk_sys(clk_sys), .cmp_enable(cmp_enable), .pos_sel(pos_sel),
        .neg_ref(neg_ref), .ref_enable(ref_enable), .pos_a_mv(pa_mv), .pos_b_mv(pb_mv),
        .neg_mv(n_mv), .cmp_raw(cmp_raw));

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic check_reg(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] got;
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 got = rdata;
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] reg %h expected %h seen %h", a, exp, got);
        end
        @(posedge clk_sys);
    endtask

    function automatic logic [1:0] pick(input int w);
        case (w)
            0: return {1'b0, irq};
            1: return {1'b0, wake_req};
            2: return {1'b0, ref_enable};
            3: return cmp_enable;
            4: return cmp_pin_oe;
            5: return cmp_pin_out;
            6: return pos_sel;
            default: return neg_ref;
        endcase
    endfunction

    task automatic check_out(input string what, input int w, input logic [1:0] exp);
        logic [1:0] got;
        #1 got = pick(w);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
        @(posedge clk_sys);
    endtask

    function automatic logic exp_res(input int i, input logic [7:0] c);
        logic [11:0] p, n;
        p = c[2] ? pb_mv[i] : pa_mv[i];
        n = c[3] ? 12'h4CE : n_mv[i];
        return p > n;
    endfunction

    task automatic rand_volts();
        for (int i = 0; i < 2; i++) begin
            pa_mv[i] <= 12'($urandom % 2048);
            pb_mv[i] <= 12'($urandom % 2048);
            n_mv[i] <= 12'($urandom % 2048);
        end
    endtask

    initial begin
        void'($urandom(88));
        pa_mv <= {12'd800, 12'd800};
        n_mv <= {12'd1000, 12'd1000};
        tick(20);
        reset <= 1'b0;
        @(posedge clk_sys);
        // reset state and unmapped place
        check_reg(`CMP_OFS_CFG0, 8'h10);
        check_reg(`CMP_OFS_CFG1, 8'h10);
        check_reg(`CMP_OFS_FLAGS, 8'h00);
        check_reg(`CMP_OFS_MASK, 8'h00);
        check_reg(`CMP_OFS_PWR, 8'h00);
        check_out("pin", 5, 2'b11);
        check_out("oe", 4, 2'b00);
        wr_reg(4'hF, 8'hFF);
        check_reg(4'hF, 8'h00);
        check_reg(`CMP_OFS_CFG0, 8'h10);
        // channel 0: enable low, clear, arm, then edges both ways
        wr_reg(`CMP_OFS_CFG0, 8'h01);
        tick(20);
        check_reg(`CMP_OFS_CFG0, 8'hC1);
        wr_reg(`CMP_OFS_CFG0, 8'h01);
        check_reg(`CMP_OFS_CFG0, 8'h81);
        wr_reg(`CMP_OFS_CFG0, 8'h21);
        check_out("irq", 0, 2'b00);
        pa_mv[0] <= 12'd1200;
        tick(12);
        check_out("irq", 0, 2'b01);
        check_reg(`CMP_OFS_CFG0, 8'hF1);
        check_reg(`CMP_OFS_FLAGS, 8'h01);
        check_reg(`CMP_OFS_MASK, 8'h01);
        wr_reg(`CMP_OFS_FLAGS, 8'h01);
        check_out("irq", 0, 2'b00);
        pa_mv[0] <= 12'd800;
        tick(12);
        check_reg(`CMP_OFS_CFG0, 8'hE1);
        wr_reg(`CMP_OFS_CFG0, 8'h21);
        // wake from idle, none in total power-down
        idle_mode <= 1'b1;
        pa_mv[0] <= 12'd1200;
        tick(12);
        check_out("wake", 1, 2'b01);
        total_power_down <= 1'b1;
        tick(4);
        check_out("enable", 3, 2'b00);
        check_out("wake", 1, 2'b00);
        total_power_down <= 1'b0;
        idle_mode <= 1'b0;
        power_down_mode <= 1'b1;
        tick(2);
        check_out("wake", 1, 2'b01);
        power_down_mode <= 1'b0;
        // power control bit
        wr_reg(`CMP_OFS_PWR, 8'h20);
        tick(2);
        check_out("enable", 3, 2'b00);
        check_reg(`CMP_OFS_PWR, 8'h20);
        wr_reg(`CMP_OFS_PWR, 8'h00);
        tick(2);
        check_out("enable", 3, 2'b01);
        // channel 1 disabled while low with its interrupt on
        wr_reg(`CMP_OFS_CFG1, 8'h01);
        tick(20);
        wr_reg(`CMP_OFS_CFG1, 8'h21);
        wr_reg(`CMP_OFS_FLAGS, 8'h03);
        check_out("irq", 0, 2'b00);
        wr_reg(`CMP_OFS_CFG1, 8'h60);
        tick(12);
        check_out("irq", 0, 2'b01);
        check_reg(`CMP_OFS_CFG1, 8'h70);
        wr_reg(`CMP_OFS_CFG1, 8'h00);
        check_reg(`CMP_OFS_CFG1, 8'h10);
        wr_reg(`CMP_OFS_CFG1, 8'h01);
        tick(20);
        // random configurations and input steps on both channels
        for (int k = 0; k < 24; k++) begin
            for (int i = 0; i < 2; i++) begin
                cfg[i] = (8'($urandom) & 8'h2F) | 8'h01;
                wr_reg(`CMP_OFS_CFG0 + 4'(i), cfg[i]);
            end
            rand_volts();
            tick(12);
            wr_reg(`CMP_OFS_FLAGS, 8'h03);
            prv = {exp_res(1, cfg[1]), exp_res(0, cfg[0])};
            rand_volts();
            tick(12);
            nxt = {exp_res(1, cfg[1]), exp_res(0, cfg[0])};
            flg = prv ^ nxt;
            for (int i = 0; i < 2; i++) begin
                check_reg(`CMP_OFS_CFG0 + 4'(i), {2'b10, cfg[i][5], nxt[i], cfg[i][3:0]} | {1'b0, flg[i], 6'h00});
            end
            check_out("irq", 0, {1'b0, |(flg & {cfg[1][5], cfg[0][5]})});
            check_out("pin", 5, nxt);
            check_out("oe", 4, {cfg[1][1], cfg[0][1]});
            check_out("ref", 2, {1'b0, cfg[1][3] | cfg[0][3]});
            check_out("pos", 6, {cfg[1][2], cfg[0][2]});
            check_out("neg", 7, {cfg[1][3], cfg[0][3]});
        end
        summarize();
    end
endmodule
